// *** seb_bank.sv ***
/*
 Status and error register bank with its serial configuration port.
 The serial shifter runs on the config serial clock, the registers on
 i_clk. Assumes the host holds select high for at least four i_clk
 cycles between frames and gives no serial edge while select is high.
*/
`timescale 1ns/1ps
module seb_bank
	import seb_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	input  wire logic        i_config_serial_clock,
	input  wire logic        i_config_select_n,
	input  wire logic        i_config_serial_in,
	input  wire logic        i_init_busy,
	input  wire logic        i_state_corrupt,
	input  wire logic        i_map_check_fail,
	input  wire logic        i_reset_event,
	input  wire logic        i_power_down,
	input  wire logic [15:0] i_range_flags,
	input  wire logic [7:0]  i_sleep_mask,
	output logic             o_config_serial_out,
	output logic             o_sample_serial_out_lane0
);
	typedef enum logic [1:0] {SEB_IDLE, SEB_FRAME} seb_frame_t;

	function automatic logic w1c(input logic cur, input logic set,
		input logic clr);
		return set | (cur & ~clr);
	endfunction : w1c

	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			if (c[7] ^ d[i]) begin
				c = {c[6:0], 1'b0} ^ CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction : crc8

	function automatic logic is_ro(input logic [6:0] a);
		return a == ADDR_RO_A || a == ADDR_RO_B || a == ADDR_RO_C;
	endfunction : is_ro

	function automatic logic is_def(input logic [6:0] a);
		return a == ADDR_CHK_CFG || a == ADDR_BUS_ERR ||
			a == ADDR_PIN_SEL || a == ADDR_HEALTH || is_ro(a);
	endfunction : is_def

	function automatic logic [7:0] rd_pick(input logic [31:0] s,
		input logic [6:0] a);
		logic [7:0] b;
		b = 8'h00;
		if (a == ADDR_CHK_CFG) begin
			b = s[31:24];
		end else if (a == ADDR_BUS_ERR) begin
			b = s[23:16];
		end else if (a == ADDR_PIN_SEL) begin
			b = s[15:8];
		end else if (a == ADDR_HEALTH) begin
			b = s[7:0];
		end
		return b;
	endfunction : rd_pick

	// Core domain state
	seb_frame_t  state_r;
	seb_frame_t  state_nxt;
	logic [7:0]  cfg_r;
	logic [7:0]  bus_err_r;
	logic        sel_r;
	logic        ready_r;
	logic        rst_flag_r;
	logic        trim_r;
	logic        map_r;
	logic        busy_q_r;
	logic        nrdy_seen_r;
	logic        req_r;
	logic [31:0] snap_r;
	logic        cs_on_q;
	logic        ack_s;

	// Link domain state
	logic [4:0]  cnt_l;
	logic [23:0] sh_l;
	logic [7:0]  hdr_l;
	logic [31:0] mir_l;
	logic        ack_l;
	logic        req_l;
	logic        fresh_l;

	// Select high ends the frame on the link side without a clock edge
	wire         frame_off = i_rst | i_config_select_n;
	wire         cs_n_s    = ~cs_on_q;
	wire         ev_start  = state_r == SEB_IDLE && !cs_n_s;
	wire         ev_end    = state_r == SEB_FRAME && cs_n_s;

	seb_sync u_cs_sync (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_ce  (i_ce),
		.i_d   (~i_config_select_n),
		.o_q   (cs_on_q)
	);

	seb_sync u_ack_sync (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_ce  (i_ce),
		.i_d   (ack_l),
		.o_q   (ack_s)
	);

	seb_sync u_req_sync (
		.i_clk (i_config_serial_clock),
		.i_rst (i_rst),
		.i_ce  (1'b1),
		.i_d   (req_r),
		.o_q   (req_l)
	);

	// Frame decode, valid only in the cycle of ev_end
	wire         chk_en  = cfg_r[7:6] == CHK_ON &&
		cfg_r[1:0] == CHK_ON_N;
	wire [4:0]   want    = chk_en ? FRAME_CHK : FRAME_BITS;
	wire         cnt_bad = cnt_l != want;
	wire [15:0]  frm     = chk_en ? sh_l[23:8] : sh_l[15:0];
	wire         crc_bad = chk_en && !cnt_bad &&
		crc8(frm) != sh_l[7:0];
	wire         rd_op   = frm[15];
	wire [6:0]   addr    = frm[14:8];
	wire [7:0]   wd      = frm[7:0];
	wire         ok      = ev_end && !nrdy_seen_r && !cnt_bad && !crc_bad;
	wire         ainv    = ok && !is_def(addr);
	wire         winv    = ok && !rd_op && is_ro(addr);
	wire         wr      = ok && !rd_op && is_def(addr) && !is_ro(addr);
	wire         wr_cfg  = wr && addr == ADDR_CHK_CFG;
	wire         wr_be   = wr && addr == ADDR_BUS_ERR;
	wire         wr_sel  = wr && addr == ADDR_PIN_SEL;
	wire         wr_hs   = wr && addr == ADDR_HEALTH;

	wire         nrdy_ev = ev_end && nrdy_seen_r;
	wire         edge_ev = ev_end && !nrdy_seen_r && cnt_bad;
	wire         crc_ev  = ev_end && !nrdy_seen_r && crc_bad;
	wire [7:0]   be_set  = {nrdy_ev, 2'b00, edge_ev, crc_ev, winv,
		1'b0, ainv};
	wire [7:0]   be_clr  = wr_be ? (wd & BE_W1C) : 8'h00;
	wire [7:0]   be_rw   = wr_be ? (wd & BE_RW) : (bus_err_r & BE_RW);
	// Set terms are ORed last so a new error beats a same-cycle clear
	wire [7:0]   be_nxt  = ((bus_err_r & BE_W1C & ~be_clr) | be_rw |
		be_set) & BE_MASK;
	wire [7:0]   hs_clr  = wr_hs ? wd : 8'h00;
	wire         busy_fall = busy_q_r & ~i_init_busy;
	wire         ready_nxt = (busy_fall | ready_r) &
		~i_state_corrupt;
	wire         rst_nxt  = w1c(rst_flag_r, i_reset_event,
		hs_clr[HS_RST]);
	wire         trim_nxt = w1c(trim_r, i_state_corrupt,
		hs_clr[HS_TRIM]);
	wire         map_nxt  = w1c(map_r, i_map_check_fail,
		hs_clr[HS_MAP]);
	wire [7:0]   cfg_nxt  = wr_cfg ? (wd & CHK_MASK) : cfg_r;
	wire         sel_nxt  = wr_sel ? wd[PS_SEL] : sel_r;

	wire [7:0]   health_live;
	assign health_live[HS_READY] = ready_r;
	assign health_live[HS_RST]   = rst_flag_r;
	assign health_live[HS_TRIM]  = trim_r;
	assign health_live[HS_MAP]   = map_r;
	assign health_live[HS_BUS]   = |bus_err_r;
	assign health_live[HS_RANGE] = |i_range_flags;
	assign health_live[HS_PD]    = i_power_down;
	assign health_live[HS_SLEEP] = |i_sleep_mask;

	wire [7:0]   sel_byte = 8'(sel_r) << PS_SEL;
	// Snapshot only once the last frame has been decoded, so that a read
	// sees the effects of the frame just before it
	wire         load     = state_r == SEB_IDLE && cs_n_s &&
		req_r == ack_s;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SEB_IDLE: begin
				if (ev_start) begin
					state_nxt = SEB_FRAME;
				end
			end
			SEB_FRAME: begin
				if (ev_end) begin
					state_nxt = SEB_IDLE;
				end
			end
			default: begin
				state_nxt = SEB_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_r     <= SEB_IDLE;
			cfg_r       <= RST_CHK_CFG;
			bus_err_r   <= RST_BUS_ERR;
			sel_r       <= RST_PIN_SEL[PS_SEL];
			ready_r     <= RST_HEALTH[HS_READY];
			rst_flag_r  <= RST_HEALTH[HS_RST];
			trim_r      <= RST_HEALTH[HS_TRIM];
			map_r       <= RST_HEALTH[HS_MAP];
			busy_q_r    <= 1'b1;
			nrdy_seen_r <= 1'b0;
		end else if (i_ce) begin
			state_r     <= state_nxt;
			cfg_r       <= cfg_nxt;
			bus_err_r   <= be_nxt;
			sel_r       <= sel_nxt;
			ready_r     <= ready_nxt;
			rst_flag_r  <= rst_nxt;
			trim_r      <= trim_nxt;
			map_r       <= map_nxt;
			busy_q_r    <= i_init_busy;
			if (ev_start) begin
				nrdy_seen_r <= !ready_r;
			end
		end
	end

	// Snapshot of the readable registers handed to the link side
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			req_r  <= 1'b0;
			snap_r <= {RST_CHK_CFG, RST_BUS_ERR, RST_PIN_SEL, RST_HEALTH};
		end else if (i_ce && load) begin
			req_r  <= ~req_r;
			snap_r <= {cfg_r, bus_err_r, sel_byte, health_live};
		end
	end

	// Link side: shift in on rising edges
	always_ff @(posedge i_config_serial_clock or posedge frame_off) begin
		if (frame_off) begin
			fresh_l <= 1'b1;
		end else begin
			fresh_l <= 1'b0;
		end
	end

	wire [4:0] cnt_inc = (cnt_l == CNT_MAX) ? cnt_l : 5'(cnt_l + 5'h01);
	wire [4:0] cnt_nxt = fresh_l ? 5'h01 : cnt_inc;

	always_ff @(posedge i_config_serial_clock or posedge i_rst) begin
		if (i_rst) begin
			cnt_l <= 5'h00;
			sh_l  <= 24'h000000;
			hdr_l <= 8'h00;
			mir_l <= {RST_CHK_CFG, RST_BUS_ERR, RST_PIN_SEL, RST_HEALTH};
			ack_l <= 1'b0;
		end else begin
			cnt_l <= cnt_nxt;
			sh_l  <= {sh_l[22:0], i_config_serial_in};
			if (cnt_nxt == HDR_BITS) begin
				hdr_l <= {sh_l[6:0], i_config_serial_in};
			end
			if (req_l != ack_l) begin
				mir_l <= snap_r;
				ack_l <= req_l;
			end
		end
	end

	// Read data leaves on falling edges during the data byte
	wire [7:0] rd_byte = rd_pick(mir_l, hdr_l[6:0]);
	wire       rd_on   = hdr_l[7] && cnt_l[4:3] == 2'b01;
	wire       rd_bit  = rd_on ? rd_byte[~cnt_l[2:0]] : 1'b0;
	wire       mir_sel = mir_l[8 + PS_SEL];

	always_ff @(negedge i_config_serial_clock or posedge frame_off) begin
		if (frame_off) begin
			o_config_serial_out       <= 1'b0;
			o_sample_serial_out_lane0 <= 1'b0;
		end else begin
			o_config_serial_out       <= mir_sel ? 1'b0 : rd_bit;
			o_sample_serial_out_lane0 <= mir_sel ? rd_bit : 1'b0;
		end
	end

	sequence s_end;
		state_r == SEB_FRAME && cs_n_s && i_ce;
	endsequence

	a_not_ready_err: assert property (
		@(posedge i_clk) disable iff (i_rst)
		s_end ##0 nrdy_seen_r |=> bus_err_r[BE_NRDY])
		else $error("frame before ready left no error");

	a_edge_cnt_err: assert property (
		@(posedge i_clk) disable iff (i_rst)
		s_end ##0 (!nrdy_seen_r && cnt_bad) |=> bus_err_r[BE_EDGE])
		else $error("bad edge count not flagged");

	a_crc_mismatch: assert property (
		@(posedge i_clk) disable iff (i_rst)
		s_end ##0 (!nrdy_seen_r && crc_bad) |=> bus_err_r[BE_CRC])
		else $error("checksum mismatch not flagged");

	a_write_ro_err: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_ce && winv |=> bus_err_r[BE_WINV] && health_live[HS_BUS])
		else $error("write to read-only not flagged");

	a_addr_bad_err: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_ce && ainv |=> bus_err_r[BE_AINV])
		else $error("undefined address not flagged");

	a_route_lane: assert property (
		@(posedge i_config_serial_clock) disable iff (i_rst)
		!mir_sel |-> !o_sample_serial_out_lane0)
		else $error("lane zero driven while config pin selected");

	a_ready_rise: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_ce && busy_q_r && !i_init_busy && !i_state_corrupt
		|=> ready_r)
		else $error("ready did not follow busy fall");

	a_ready_drop: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_ce && i_state_corrupt |=> !ready_r && trim_r)
		else $error("corruption left ready set");

	a_reset_flag: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_ce && i_reset_event |=> health_live[HS_RST])
		else $error("reset event not flagged");

	a_check_gate: assert property (
		@(posedge i_clk) disable iff (i_rst)
		s_end ##0 (!chk_en && !nrdy_seen_r && !wr_be &&
			cnt_l == FRAME_BITS)
		|=> $stable(bus_err_r[BE_EDGE]) && $stable(bus_err_r[BE_CRC]))
		else $error("check gate misread");

	a_w1c_keep: assert property (
		@(posedge i_clk) disable iff (i_rst)
		i_ce && wr_be && !wd[BE_NRDY] && bus_err_r[BE_NRDY]
		|=> bus_err_r[BE_NRDY])
		else $error("write of zero cleared a flag");
endmodule : seb_bank

// *** seb_pkg.sv ***
/*
 Constants of the status and error register bank: register offsets,
 field positions, reset values and serial frame sizes.
 Assumes byte-wide registers reached over the serial configuration bus.
*/
// Summary of operation
// - Frame started before device ready sets bus error bit 7; write one clears.
// - Wrong serial clock edge count sets bus error bit 4, a plain R/W bit.
// - With checking on, received checksum mismatch sets bit 3; write one clears.
// - Write to an all read-only register sets bit 2; write one clears.
// - Read or write of an undefined address sets bit 0; write one clears.
// - Select bit 0 sends read data to config pin, 1 to lane zero.
// - Ready bit 7 rises when busy falls after initialization; reads 0 before.
// - Ready at 0 after initialization means corrupt state; host must reset.
// - Reset flag bit 6 sets on every reset event, resets to 1, W1C.
// - Internal state corruption sets trim flag bit 5, W1C; host must reset.
// - Map check mismatch sets bit 4, W1C; host inspects map or ignores.
// - Status bit 3 is the OR of all bus error bits.
// - Status bit 2 is the OR of all channel range flags.
// - Status bit 1 is 1 exactly while powered down.
// - Status bit 0 is the OR of all channel sleep bits.
// - Checking is on only when enable field is 1 and inverse field 2.
package seb_pkg;
	localparam logic [6:0] ADDR_CHK_CFG = 7'h10;
	localparam logic [6:0] ADDR_BUS_ERR = 7'h11;
	localparam logic [6:0] ADDR_PIN_SEL = 7'h14;
	localparam logic [6:0] ADDR_HEALTH  = 7'h20;
	// Read-only registers of the wider map, held elsewhere
	localparam logic [6:0] ADDR_RO_A    = 7'h0b;
	localparam logic [6:0] ADDR_RO_B    = 7'h0c;
	localparam logic [6:0] ADDR_RO_C    = 7'h0d;

	localparam int BE_NRDY = 7;
	localparam int BE_EDGE = 4;
	localparam int BE_CRC  = 3;
	localparam int BE_WINV = 2;
	localparam int BE_AINV = 0;
	localparam logic [7:0] BE_W1C  = 8'h8d;
	localparam logic [7:0] BE_RW   = 8'h10;
	localparam logic [7:0] BE_MASK = 8'h9d;

	localparam int HS_READY = 7;
	localparam int HS_RST   = 6;
	localparam int HS_TRIM  = 5;
	localparam int HS_MAP   = 4;
	localparam int HS_BUS   = 3;
	localparam int HS_RANGE = 2;
	localparam int HS_PD    = 1;
	localparam int HS_SLEEP = 0;

	localparam int PS_SEL = 0;

	localparam logic [7:0] RST_CHK_CFG = 8'h03;
	localparam logic [7:0] RST_BUS_ERR = 8'h00;
	localparam logic [7:0] RST_PIN_SEL = 8'h00;
	localparam logic [7:0] RST_HEALTH  = 8'h40;

	localparam logic [1:0] CHK_ON   = 2'h1;
	localparam logic [1:0] CHK_ON_N = 2'h2;
	localparam logic [7:0] CHK_MASK = 8'hc3;

	localparam logic [4:0] HDR_BITS   = 5'h08;
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] FRAME_CHK  = 5'h18;
	localparam logic [4:0] CNT_MAX    = 5'h1f;
	localparam logic [7:0] CRC_POLY   = 8'h07;
	localparam logic [7:0] CRC_INIT   = 8'h00;
endpackage : seb_pkg

// *** seb_sync.sv ***
/*
 Two-flop synchroniser for a single level.
 Assumes i_d is stable long enough for the receiving clock to see it.
*/
`timescale 1ns/1ps
module seb_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_ce,
	input  wire logic i_d,
	output logic      o_q
);
	logic meta_r;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_r <= RST_VAL;
			o_q    <= RST_VAL;
		end else if (i_ce) begin
			meta_r <= i_d;
			o_q    <= meta_r;
		end
	end

endmodule : seb_sync

// *** seb_host.sv ***
/*
 Host controller model for the serial configuration port of the bank.
 Assumes the bank samples on the rising serial clock edge and drives read
 data on the falling edge; serial clock rests low outside frames.
*/
`timescale 1ns/1ps
module seb_host (
	output logic      o_config_serial_clock,
	output logic      o_config_select_n,
	output logic      o_config_serial_in,
	input  wire logic i_config_serial_out,
	input  wire logic i_sample_serial_out_lane0
);
	initial begin
		o_config_serial_clock = 1'b0;
		o_config_select_n     = 1'b1;
		o_config_serial_in    = 1'b0;
	end

	// One frame: header, data byte, optional checksum byte; n edges
	task automatic xfer(input logic rd, input logic [6:0] a,
			input logic [7:0] d, input logic crc_on, input logic bad,
			input int n, output logic [7:0] q, output logic [7:0] ql);
		logic [23:0] f;
		logic [7:0]  c;
		int          k;
		f = {rd, a, d, 8'h00};
		c = 8'h00;
		q = 8'h00;
		ql = 8'h00;
		for (k = 0; k < 16; k++) begin
			if (c[7] ^ f[23-k])
				c = {c[6:0], 1'b0} ^ 8'h07;
			else
				c = {c[6:0], 1'b0};
		end
		f[7:0] = c ^ {7'h00, bad};
		if (!crc_on)
			f = {f[23:8], 8'h00} << 0;
		o_config_select_n = 1'b0;
		#10;
		for (k = 0; k < n; k++) begin
			o_config_serial_in = f[23-k];
			#3;
			o_config_serial_clock = 1'b1;
			if (k >= 8 && k < 16) begin
				q  = {q[6:0], i_config_serial_out};
				ql = {ql[6:0], i_sample_serial_out_lane0};
			end
			#3;
			o_config_serial_clock = 1'b0;
		end
		#10;
		o_config_select_n = 1'b1;
		// Released data line must not keep its last value
		o_config_serial_in = ~o_config_serial_in;
		#1000;
	endtask : xfer
endmodule : seb_host

// *** seb_bank_tb.sv ***
/*
 Self-checking testbench of the status and error register bank.
 Assumes the host model frames stay 1 us apart, well above the gap.
*/
`timescale 1ns/1ps
module seb_bank_tb;
	import seb_pkg::*;
	logic        i_clk, i_rst, i_init_busy, i_state_corrupt;
	logic        i_map_check_fail, i_reset_event, i_power_down;
	logic [15:0] i_range_flags;
	logic [7:0]  i_sleep_mask;
	logic        sclk, sel_n, sdi, cfg_out, lane_out;
	logic        crc, lane, ce;
	logic [7:0]  q, ql;
	int          fails, cmp_count, cyc;

	seb_bank seb_bank_i (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
		.i_config_serial_clock(sclk), .i_config_select_n(sel_n),
		.i_config_serial_in(sdi), .i_init_busy(i_init_busy),
		.i_state_corrupt(i_state_corrupt),
		.i_map_check_fail(i_map_check_fail), .i_reset_event(i_reset_event),
		.i_power_down(i_power_down), .i_range_flags(i_range_flags),
		.i_sleep_mask(i_sleep_mask), .o_config_serial_out(cfg_out),
		.o_sample_serial_out_lane0(lane_out));
	seb_host seb_host_i (.o_config_serial_clock(sclk),
		.o_config_select_n(sel_n), .o_config_serial_in(sdi),
		.i_config_serial_out(cfg_out), .i_sample_serial_out_lane0(lane_out));

	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic raw(input logic rd, input logic [6:0] a,
			input logic [7:0] d, input logic bad, input int n);
		seb_host_i.xfer(rd, a, d, crc, bad, n, q, ql);
	endtask : raw

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		raw(1'b0, a, d, 1'b0, crc ? 24 : 16);
	endtask : wr

	// Read data on the selected pin, zero on the other
	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		raw(1'b1, a, 8'h00, 1'b0, crc ? 24 : 16);
		chk(lane ? ql : q, exp);
		chk(lane ? q : ql, 8'h00);
	endtask : rd

	task automatic settle();
		repeat (5) @(negedge i_clk);
	endtask : settle

	// Reads show the snapshot taken after the previous frame, so one
	// spare frame lets new input levels reach the next read
	task automatic refresh();
		raw(1'b1, ADDR_HEALTH, 8'h00, 1'b0, 16);
	endtask : refresh

	task automatic done(input string name);
		$display("test %s finished", name);
	endtask : done

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			print_verdict();
		end
	end

	task automatic do_reset();
		@(negedge i_clk);
		i_rst = 1'b1;
		i_init_busy = 1'b1;
		repeat (3) @(negedge i_clk);
		i_rst = 1'b0;
		settle();
	endtask : do_reset

	initial begin
		{i_rst, i_state_corrupt, i_map_check_fail, i_reset_event} = 4'h8;
		{i_power_down, crc, lane, ce} = 4'h1;
		{i_range_flags, i_sleep_mask} = 24'h000000;
		i_init_busy = 1'b1;
		{fails, cmp_count, cyc} = 0;
		do_reset();
		raw(1'b1, ADDR_HEALTH, 8'h00, 1'b0, 16);
		@(negedge i_clk);
		i_init_busy = 1'b0;
		settle();
		refresh();
		rd(ADDR_HEALTH, 8'hc8);
		rd(ADDR_BUS_ERR, 8'h80);
		wr(ADDR_BUS_ERR, 8'h0d);
		rd(ADDR_BUS_ERR, 8'h80);
		wr(ADDR_BUS_ERR, 8'h8d);
		rd(ADDR_BUS_ERR, 8'h00);
		rd(ADDR_CHK_CFG, 8'h03);
		rd(ADDR_PIN_SEL, 8'h00);
		done("not ready");
		wr(ADDR_HEALTH, 8'h40);
		rd(ADDR_HEALTH, 8'h80);
		// Clock enable low: the event pulse must be missed
		@(negedge i_clk);
		{ce, i_reset_event} = 2'h1;
		@(negedge i_clk);
		{ce, i_reset_event} = 2'h2;
		settle();
		refresh();
		rd(ADDR_HEALTH, 8'h80);
		@(negedge i_clk);
		i_reset_event = 1'b1;
		@(negedge i_clk);
		i_reset_event = 1'b0;
		settle();
		refresh();
		rd(ADDR_HEALTH, 8'hc0);
		wr(ADDR_HEALTH, 8'h40);
		done("reset flag");
		raw(1'b0, ADDR_PIN_SEL, 8'h01, 1'b0, 12);
		rd(ADDR_BUS_ERR, 8'h10);
		rd(ADDR_PIN_SEL, 8'h00);
		wr(ADDR_BUS_ERR, 8'h00);
		rd(ADDR_BUS_ERR, 8'h00);
		done("edge count");
		raw(1'b1, 7'h7f, 8'h00, 1'b0, 16);
		rd(ADDR_RO_A, 8'h00);
		wr(ADDR_RO_B, 8'h55);
		rd(ADDR_BUS_ERR, 8'h05);
		rd(ADDR_HEALTH, 8'h88);
		wr(ADDR_BUS_ERR, 8'h04);
		rd(ADDR_BUS_ERR, 8'h01);
		wr(ADDR_BUS_ERR, 8'h01);
		rd(ADDR_BUS_ERR, 8'h00);
		done("address");
		wr(ADDR_CHK_CFG, 8'hff);
		rd(ADDR_CHK_CFG, 8'hc3);
		wr(ADDR_CHK_CFG, 8'h42);
		crc = 1'b1;
		rd(ADDR_CHK_CFG, 8'h42);
		raw(1'b0, ADDR_PIN_SEL, 8'h01, 1'b1, 24);
		rd(ADDR_BUS_ERR, 8'h08);
		rd(ADDR_PIN_SEL, 8'h00);
		wr(ADDR_BUS_ERR, 8'h08);
		rd(ADDR_BUS_ERR, 8'h00);
		wr(ADDR_CHK_CFG, 8'h41);
		crc = 1'b0;
		rd(ADDR_CHK_CFG, 8'h41);
		rd(ADDR_BUS_ERR, 8'h00);
		wr(ADDR_CHK_CFG, 8'h03);
		done("checksum");
		wr(ADDR_PIN_SEL, 8'h01);
		lane = 1'b1;
		rd(ADDR_PIN_SEL, 8'h01);
		wr(ADDR_PIN_SEL, 8'hff);
		rd(ADDR_PIN_SEL, 8'h01);
		wr(ADDR_PIN_SEL, 8'h00);
		lane = 1'b0;
		rd(ADDR_PIN_SEL, 8'h00);
		done("pin select");
		@(negedge i_clk);
		i_power_down = 1'b1;
		i_range_flags = 16'h0100;
		i_sleep_mask = 8'h80;
		settle();
		refresh();
		rd(ADDR_HEALTH, 8'h87);
		@(negedge i_clk);
		{i_power_down, i_range_flags, i_sleep_mask} = 25'h0;
		i_map_check_fail = 1'b1;
		@(negedge i_clk);
		i_map_check_fail = 1'b0;
		settle();
		refresh();
		rd(ADDR_HEALTH, 8'h90);
		wr(ADDR_HEALTH, 8'h10);
		rd(ADDR_HEALTH, 8'h80);
		// Corruption drops ready, so every later frame up to the next reset is flagged and its write ignored
		@(negedge i_clk);
		i_state_corrupt = 1'b1;
		@(negedge i_clk);
		i_state_corrupt = 1'b0;
		settle();
		refresh();
		rd(ADDR_HEALTH, 8'h28);
		wr(ADDR_HEALTH, 8'h20);
		rd(ADDR_HEALTH, 8'h28);
		rd(ADDR_BUS_ERR, 8'h80);
		done("health");
		do_reset();
		@(negedge i_clk);
		i_init_busy = 1'b0;
		settle();
		refresh();
		rd(ADDR_HEALTH, 8'hc0);
		rd(ADDR_CHK_CFG, 8'h03);
		done("second reset");
		print_verdict();
	end
endmodule : seb_bank_tb
